// File: nscr_pkg.sv
// Purpose: Shared constants for the node switch configuration bank
// Assumes: Registers are addressed by an 8-bit configuration number
// Notes:   Reset values of PLL fields come from a strap-indexed table
package nscr_pkg;
    // Register numbers
    localparam logic [7:0] REG_IDENT  = 8'h00;
    localparam logic [7:0] REG_DESCR  = 8'h01;
    localparam logic [7:0] REG_CFG    = 8'h04;
    localparam logic [7:0] REG_NODEID = 8'h05;
    localparam logic [7:0] REG_PLL    = 8'h06;

    // Field positions
    localparam int CFG_WLOCK_BIT  = 31;
    localparam int CFG_PLOCK_BIT  = 8;
    localparam int CFG_HDR_BIT    = 0;
    localparam int NODEID_W       = 16;
    localparam int PLL_OUTDIV_LSB = 23;
    localparam int PLL_OUTDIV_W   = 3;
    localparam int PLL_F_LSB      = 8;
    localparam int PLL_F_W        = 13;
    localparam int PLL_R_LSB      = 0;
    localparam int PLL_R_W        = 7;
    localparam int ID_CHIP_LSB    = 24;
    localparam int ID_STRAP_LSB   = 16;
    localparam int ID_REV_LSB     = 8;
    localparam int ID_VER_LSB     = 0;
    localparam int DS_LINKS_LSB   = 16;
    localparam int DS_CORES_LSB   = 8;
    localparam int DS_LPP_LSB     = 0;

    // Reset values
    localparam logic        CFG_BIT_RST = 1'b0;
    localparam logic [15:0] NODEID_RST  = 16'h0000;

    // PLL reset values, indexed by {strap1, strap0}
    localparam logic [2:0]  PLL_OUTDIV_TAB [4] = '{3'h1, 3'h1, 3'h1, 3'h1};
    localparam logic [12:0] PLL_F_TAB  [4] =
        '{13'h0031, 13'h0063, 13'h007C, 13'h0018};
    localparam logic [6:0]  PLL_R_TAB  [4] = '{7'h00, 7'h03, 7'h04, 7'h00};
endpackage : nscr_pkg

// File: nscr_route_if.sv
// Purpose: Carries node identifier and destination to the route matcher
// Assumes: One destination compared per cycle
// Notes:   Matcher output is purely combinational
`timescale 1ns/100ps
interface nscr_route_if;
    logic [15:0] node_id;
    logic [15:0] dest;
    logic        local_hit;
    logic [3:0]  mismatch_bit;

    modport bank (output node_id, output dest,
                  input local_hit, input mismatch_bit);
    modport match (input node_id, input dest,
                   output local_hit, output mismatch_bit);
endinterface : nscr_route_if

// File: nscr_route_match.sv
// Purpose: Compares node identifier with a message destination
// Assumes: Identifier width of 16 bits
// Notes:   Scan runs from bit 0 upward; the highest differing bit wins
`timescale 1ns/100ps
module nscr_route_match (
    nscr_route_if.match rt
);
    logic [15:0] diff;

    // Highest differing bit wins; the loop runs upward so it overwrites
    always_comb begin
        diff            = rt.node_id ^ rt.dest;
        rt.local_hit    = (diff == 16'h0000);
        rt.mismatch_bit = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (diff[i]) begin
                rt.mismatch_bit = 4'(i);
            end
        end
    end
endmodule // nscr_route_match

// File: nscr_bank.sv
// Purpose: Configuration register bank of the node system router
// Assumes: Requester holds one access per cycle; inputs synchronous
// Notes:   PLL fields drive the external PLL that clocks tile and router
// Function
// - Registers reached only by config reads and writes, served by number.
// - Ident register: chip id, reset straps, revision, version bytes.
// - Description register: links, cores, links per processor; top zero.
// - Bit 31 of config register set refuses every write.
// - Bit 8 of config register set blocks PLL register updates.
// - Bit 0 of config register selects 1-byte packet headers.
// - Node identifier: writable low 16 bits, reset zero, upper zero.
// - Node identifier compared MSB first with message destinations.
// - Accepted PLL register write resets the processor tile.
// - PLL register holds output divider, multiplier, input divider.
// - PLL field reset values chosen from the two strap pins.
// - Multiplied PLL clock feeds I/O, processor and router.
`timescale 1ns/100ps
module nscr_bank #(
    parameter logic [7:0] CHIP_ID   = 8'h5A, // Arbitrary value
    parameter logic [7:0] REVISION  = 8'h01, // Arbitrary value
    parameter logic [7:0] VERSION   = 8'h01, // Arbitrary value
    parameter int         NUM_LINKS = 8,
    parameter int         NUM_CORES = 1,
    parameter int         LINKS_PP  = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        boot_strap_pin_0,
    input  wire logic        boot_strap_pin_1,
    input  wire logic        cfg_valid,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_num,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ready,
    output logic             cfg_rvalid,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_wack,
    output logic             cfg_werr,
    input  wire logic [15:0] msg_dest,
    output logic             msg_local,
    output logic [3:0]       msg_mismatch_bit,
    output logic             header_1byte,
    output logic [15:0]      node_id,
    output logic [2:0]       pll_output_divider,
    output logic [12:0]      pll_feedback_mult,
    output logic [6:0]       pll_input_divider,
    output logic             tile_rst_pulse
);
    // Counts must fit their byte fields
    if (NUM_LINKS < 0 || NUM_LINKS > 255 || NUM_CORES < 0 ||
        NUM_CORES > 255 || LINKS_PP < 0 || LINKS_PP > 255) begin : g_chk
        $error("nscr_bank: description counts exceed one byte");
    end

    logic        strap_done_r;
    logic [1:0]  strap_r;
    logic        wlock_r;
    logic        plock_r;
    logic        hdr_r;
    logic [15:0] node_id_r;
    logic [2:0]  outdiv_r;
    logic [12:0] fm_r;
    logic [6:0]  idv_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic        wack_r;
    logic        werr_r;
    logic        trst_r;
    logic        wr_take;
    logic        wr_ok;
    logic        pll_wr_ok;
    logic [31:0] rd_nxt;

    nscr_route_if rt ();

    // Requests wait until straps are captured so the PLL defaults exist
    assign cfg_ready = strap_done_r;
    assign wr_take   = cfg_valid && cfg_ready && cfg_write;
    assign wr_ok     = wr_take && !wlock_r;
    assign pll_wr_ok = wr_ok && (cfg_num == nscr_pkg::REG_PLL)
                       && !plock_r;

    // Strap levels and PLL defaults caught at the first edge after reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_r <= 1'b0;
            strap_r      <= 2'b00;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            strap_r      <= {boot_strap_pin_1, boot_strap_pin_0};
        end
    end

    // Protection and header mode; the write lock also guards itself,
    // so once set it can only be cleared by reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wlock_r <= nscr_pkg::CFG_BIT_RST;
            plock_r <= nscr_pkg::CFG_BIT_RST;
            hdr_r   <= nscr_pkg::CFG_BIT_RST;
        end else if (wr_ok && cfg_num == nscr_pkg::REG_CFG) begin
            wlock_r <= cfg_wdata[nscr_pkg::CFG_WLOCK_BIT];
            plock_r <= cfg_wdata[nscr_pkg::CFG_PLOCK_BIT];
            hdr_r   <= cfg_wdata[nscr_pkg::CFG_HDR_BIT];
        end
    end

    // Node identifier
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            node_id_r <= nscr_pkg::NODEID_RST;
        end else if (wr_ok && cfg_num == nscr_pkg::REG_NODEID) begin
            node_id_r <= cfg_wdata[nscr_pkg::NODEID_W-1:0];
        end
    end

    // PLL settings: strap table at capture, then software writes.
    // A write blocked by either lock leaves all three fields alone.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            outdiv_r <= 3'h0;
            fm_r     <= 13'h0000;
            idv_r    <= 7'h00;
        end else if (!strap_done_r) begin
            outdiv_r <= nscr_pkg::PLL_OUTDIV_TAB[{boot_strap_pin_1,
                                                   boot_strap_pin_0}];
            fm_r     <= nscr_pkg::PLL_F_TAB[{boot_strap_pin_1,
                                             boot_strap_pin_0}];
            idv_r    <= nscr_pkg::PLL_R_TAB[{boot_strap_pin_1,
                                             boot_strap_pin_0}];
        end else if (pll_wr_ok) begin
            outdiv_r <= cfg_wdata[nscr_pkg::PLL_OUTDIV_LSB +:
                                  nscr_pkg::PLL_OUTDIV_W];
            fm_r     <= cfg_wdata[nscr_pkg::PLL_F_LSB +: nscr_pkg::PLL_F_W];
            idv_r    <= cfg_wdata[nscr_pkg::PLL_R_LSB +: nscr_pkg::PLL_R_W];
        end
    end

    // Tile reset pulse follows only an accepted PLL write
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            trst_r <= 1'b0;
        end else begin
            trst_r <= pll_wr_ok;
        end
    end

    // Read mux; unmapped numbers and reserved bits read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (cfg_num)
            nscr_pkg::REG_IDENT: begin
                rd_nxt[nscr_pkg::ID_CHIP_LSB +: 8]  = CHIP_ID;
                rd_nxt[nscr_pkg::ID_STRAP_LSB +: 2] = strap_r;
                rd_nxt[nscr_pkg::ID_REV_LSB +: 8]   = REVISION;
                rd_nxt[nscr_pkg::ID_VER_LSB +: 8]   = VERSION;
            end
            nscr_pkg::REG_DESCR: begin
                rd_nxt[nscr_pkg::DS_LINKS_LSB +: 8] = 8'(NUM_LINKS);
                rd_nxt[nscr_pkg::DS_CORES_LSB +: 8] = 8'(NUM_CORES);
                rd_nxt[nscr_pkg::DS_LPP_LSB +: 8]   = 8'(LINKS_PP);
            end
            nscr_pkg::REG_CFG: begin
                rd_nxt[nscr_pkg::CFG_WLOCK_BIT] = wlock_r;
                rd_nxt[nscr_pkg::CFG_PLOCK_BIT] = plock_r;
                rd_nxt[nscr_pkg::CFG_HDR_BIT]   = hdr_r;
            end
            nscr_pkg::REG_NODEID: begin
                rd_nxt[nscr_pkg::NODEID_W-1:0] = node_id_r;
            end
            nscr_pkg::REG_PLL: begin
                rd_nxt[nscr_pkg::PLL_OUTDIV_LSB +:
                       nscr_pkg::PLL_OUTDIV_W] = outdiv_r;
                rd_nxt[nscr_pkg::PLL_F_LSB +: nscr_pkg::PLL_F_W]   = fm_r;
                rd_nxt[nscr_pkg::PLL_R_LSB +: nscr_pkg::PLL_R_W]   = idv_r;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Answers come one cycle after the request is taken
    // Reads outside the map answer with zero rather than an error
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            wack_r   <= 1'b0;
            werr_r   <= 1'b0;
        end else begin
            rvalid_r <= cfg_valid && cfg_ready && !cfg_write;
            rdata_r  <= (cfg_valid && cfg_ready && !cfg_write) ?
                        rd_nxt : 32'h0000_0000;
            wack_r   <= wr_take;
            // Refused whole-bank write, or PLL write under its lock
            werr_r   <= wr_take && (wlock_r || ((cfg_num ==
                        nscr_pkg::REG_PLL) && plock_r));
        end
    end

    // Destination match runs in the small matcher
    // Mismatch index means nothing while msg_local is high
    assign rt.node_id = node_id_r;
    assign rt.dest    = msg_dest;
    nscr_route_match u_match (
        .rt (rt.match)
    );
    assign msg_local        = rt.local_hit;
    assign msg_mismatch_bit = rt.mismatch_bit;

    // Settings leave straight from flip-flops; PLL clock source is
    assign header_1byte       = hdr_r;
    assign node_id            = node_id_r;
    assign pll_output_divider = outdiv_r;
    assign pll_feedback_mult  = fm_r;
    assign pll_input_divider  = idv_r;
    assign tile_rst_pulse     = trst_r;
    assign cfg_rvalid         = rvalid_r;
    assign cfg_rdata          = rdata_r;
    assign cfg_wack           = wack_r;
    assign cfg_werr           = werr_r;
endmodule // nscr_bank

// File: nscr_bank_assertions.sv
// Purpose: Port-level checks of the node switch configuration bank
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to every nscr_bank instance at the foot of this file
`timescale 1ns/100ps
module nscr_bank_chk #(
    parameter logic [7:0] CHIP_ID = 8'h5A // Arbitrary value
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        cfg_valid,
    input wire logic        cfg_write,
    input wire logic [7:0]  cfg_num,
    input wire logic [31:0] cfg_wdata,
    input wire logic        cfg_ready,
    input wire logic        cfg_rvalid,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_wack,
    input wire logic        cfg_werr,
    input wire logic [15:0] msg_dest,
    input wire logic        msg_local,
    input wire logic        header_1byte,
    input wire logic [15:0] node_id,
    input wire logic [2:0]  pll_output_divider,
    input wire logic        tile_rst_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Request taken on this edge
    wire logic take;
    assign take = cfg_valid && cfg_ready;

    AST_RD_ANS: assert property (take && !cfg_write |=> cfg_rvalid)
        else $error("read not answered next cycle");
    AST_WR_ANS: assert property (take && cfg_write |=> cfg_wack)
        else $error("write not answered next cycle");
    AST_ID: assert property (take && !cfg_write && cfg_num == 8'h00
        |=> cfg_rdata[31:18] == {CHIP_ID, 6'h00})
        else $error("ident top fields wrong");
    AST_DS: assert property (take && !cfg_write && cfg_num == 8'h01
        |=> cfg_rdata[31:24] == 8'h00) else $error("descr top not zero");
    // A refused write must leave node id, header mode and output divider where they were
    AST_REFUSE: assert property (cfg_wack && cfg_werr
        |-> $stable(node_id) && $stable(header_1byte)
        && $stable(pll_output_divider)) else $error("refused write acted");
    AST_PLL_RST: assert property (take && cfg_write && cfg_num == 8'h06
        |=> tile_rst_pulse == !cfg_werr) else $error("tile reset wrong");
    AST_RST_SRC: assert property (tile_rst_pulse |-> $past(cfg_valid)
        && $past(cfg_write) && $past(cfg_num) == 8'h06)
        else $error("tile reset without pll write");
    AST_HDR: assert property (take && cfg_write && cfg_num == 8'h04
        |=> cfg_werr || header_1byte == $past(cfg_wdata[0]))
        else $error("header mode not updated");
    AST_NODE: assert property (take && cfg_write && cfg_num == 8'h05
        |=> cfg_werr || node_id == $past(cfg_wdata[15:0]))
        else $error("node id not updated");
    AST_MATCH: assert property (msg_local == (msg_dest == node_id))
        else $error("local match wrong");
endmodule // nscr_bank_chk

bind nscr_bank nscr_bank_chk #(.CHIP_ID(CHIP_ID)) i_chk (
    .clk_sys, .sys_rst, .cfg_valid, .cfg_write, .cfg_num, .cfg_wdata,
    .cfg_ready, .cfg_rvalid, .cfg_rdata, .cfg_wack, .cfg_werr, .msg_dest,
    .msg_local, .header_1byte, .node_id, .pll_output_divider,
    .tile_rst_pulse
);

// File: nscr_req_model.sv
// Purpose: Configuration requester on the far side of the bank
// Assumes: Caller enters just after a rising edge
// Notes:   Released lines carry inverted junk so stale values never match
`timescale 1ns/100ps
module nscr_req_model (
    input  wire logic        clk_sys,
    input  wire logic        cfg_ready,
    input  wire logic        cfg_rvalid,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_wack,
    input  wire logic        cfg_werr,
    output logic             cfg_valid,
    output logic             cfg_write,
    output logic [7:0]       cfg_num,
    output logic [31:0]      cfg_wdata
);
    int gap = 0; // Extra idle cycles beyond the one before each request, for slow traffic
    initial begin
        cfg_valid = 1'b0;
        cfg_write = 1'b0;
        cfg_num   = 8'hFF;
        cfg_wdata = 32'h0;
    end
    // One configuration access by register number; leaves in answer cycle
    task automatic xfer(input logic w, input logic [7:0] n,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        // gap + 1 idle edges first, so valid never rises where it just fell
        repeat (gap + 1) @(posedge clk_sys) #1;
        while (cfg_ready !== 1'b1) @(posedge clk_sys) #1;
        cfg_valid = 1'b1;
        cfg_write = w;
        cfg_num   = n;
        cfg_wdata = d;
        @(posedge clk_sys) #1;
        q = cfg_rdata;
        e = cfg_werr;
        if (w ? cfg_wack !== 1'b1 : cfg_rvalid !== 1'b1) begin
            q = 'x;
            e = 1'bx;
        end
        cfg_valid = 1'b0;
        cfg_write = ~w;
        cfg_num   = ~n;
        cfg_wdata = ~d;
    endtask
endmodule // nscr_req_model

// File: nscr_bank_bench.sv
// Purpose: Self-checking bench of the node switch configuration bank
// Assumes: Straps held at {pin1,pin0} = 2'b10 through every reset
// Notes:   One header mode per node; this bench has a single node
`timescale 1ns/100ps
module nscr_bank_bench;
    localparam logic [7:0] CID = 8'h5A; // Arbitrary value
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [1:0]  strap = 2'b10;
    logic [15:0] msg_dest = 16'h0000;
    logic        cfg_valid, cfg_write, cfg_ready, cfg_rvalid, cfg_wack;
    logic        cfg_werr, msg_local, header_1byte, tile_rst_pulse, e;
    logic [7:0]  cfg_num;
    logic [31:0] cfg_wdata, cfg_rdata, q;
    logic [3:0]  msg_mismatch_bit;
    logic [15:0] node_id;
    logic [2:0]  pll_output_divider;
    logic [12:0] pll_feedback_mult;
    logic [6:0]  pll_input_divider;
    int          error_cnt = 0;
    int          compares = 0;

    always #2 clk_sys = ~clk_sys;

    nscr_bank #(.CHIP_ID(CID), .REVISION(8'h3C), .VERSION(8'h07),
        .NUM_LINKS(8), .NUM_CORES(1), .LINKS_PP(4)) i_dut (
        .clk_sys, .sys_rst, .boot_strap_pin_0(strap[0]),
        .boot_strap_pin_1(strap[1]), .cfg_valid, .cfg_write, .cfg_num,
        .cfg_wdata, .cfg_ready, .cfg_rvalid, .cfg_rdata, .cfg_wack,
        .cfg_werr, .msg_dest, .msg_local, .msg_mismatch_bit, .header_1byte,
        .node_id, .pll_output_divider, .pll_feedback_mult,
        .pll_input_divider, .tile_rst_pulse);

    nscr_req_model i_req (.clk_sys, .cfg_ready, .cfg_rvalid, .cfg_rdata,
        .cfg_wack, .cfg_werr, .cfg_valid, .cfg_write, .cfg_num, .cfg_wdata);

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task rd(input logic [7:0] n, input logic [31:0] ex);
        i_req.xfer(1'b0, n, 32'h0, q, e);
        chk("rdata", ex, q);
    endtask
    task wr(input logic [7:0] n, input logic [31:0] d, input logic er);
        i_req.xfer(1'b1, n, d, q, e);
        chk("werr", 32'(er), 32'(e));
    endtask
    task finish_test;
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog: the tests take well under a thousand cycles
    initial begin
        #8000;
        $display("BAD watchdog expected done seen hang");
        error_cnt++;
        finish_test();
    end

    // Test sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        rd(8'h00, {CID, 6'h0, strap, 8'h3C, 8'h07});
        rd(8'h01, 32'h0008_0104);
        rd(8'h04, 32'h0);
        rd(8'h06, {6'h0, nscr_pkg::PLL_OUTDIV_TAB[2], 2'h0,
            nscr_pkg::PLL_F_TAB[2], 1'b0, nscr_pkg::PLL_R_TAB[2]});
        $display("reset values done");
        wr(8'h05, 32'hFFFF_A5C3, 1'b0);
        rd(8'h05, 32'h0000_A5C3);
        msg_dest = 16'hA5C3;
        #1 chk("local", 32'h1, 32'(msg_local));
        // Destination moves just after each edge like every other input
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys) #1;
            msg_dest = 16'hA5C3 ^ (16'hFFFF >> (15 - i));
            #1;
            chk("mismatch", 32'(i),
                {27'h0, msg_local, msg_mismatch_bit});
        end
        @(posedge clk_sys) #1;
        $display("node id done");
        i_req.gap = 2;
        wr(8'h06, 32'hFFFF_FFFF, 1'b0);
        chk("tile_rst", 32'h1, 32'(tile_rst_pulse));
        chk("pll", 32'h007F_FFFF, {9'h0, pll_output_divider,
            pll_feedback_mult, pll_input_divider});
        i_req.gap = 0;
        rd(8'h06, 32'h039F_FF7F);
        $display("pll write done");
        wr(8'h04, 32'h0000_0101, 1'b0);
        chk("hdr", 32'h1, 32'(header_1byte));
        wr(8'h06, 32'h0, 1'b1);
        chk("tile_rst", 32'h0, 32'(tile_rst_pulse));
        rd(8'h06, 32'h039F_FF7F);
        wr(8'h00, 32'h0, 1'b0);
        rd(8'h02, 32'h0);
        $display("pll protect done");
        wr(8'h04, 32'h8000_0000, 1'b0);
        chk("hdr", 32'h0, 32'(header_1byte));
        wr(8'h05, 32'h0, 1'b1);
        wr(8'h04, 32'h0, 1'b1);
        rd(8'h05, 32'h0000_A5C3);
        rd(8'h04, 32'h8000_0000);
        sys_rst = 1'b1;
        @(posedge clk_sys) #1 sys_rst = 1'b0;
        rd(8'h04, 32'h0);
        $display("write lock done");
        finish_test();
    end
endmodule // nscr_bank_bench
